// ### rtl/gpf_defines.svh
/*
  Offsets, field masks, reset values and sizes of the port F block.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef GPF_DEFINES_SVH
`define GPF_DEFINES_SVH
`define GPF_NPINS 16
`define GPF_OFF_DIR 16'h6140
`define GPF_OFF_SAMPLE 16'h6150
`define GPF_OFF_HOLD 16'h6160
`define GPF_OFF_ODS 16'h6170
`define GPF_OFF_PULLUP 16'h6180
`define GPF_OFF_NOTIFY 16'h6190
`define GPF_OFF_ISTAT 16'h61A0
`define GPF_OFF_IMASK 16'h61B0
`define GPF_ALIAS_CLR 2'h1
`define GPF_ALIAS_SET 2'h2
`define GPF_ALIAS_INV 2'h3
`define GPF_MASK_SMALL 16'h003B
`define GPF_MASK_LARGE 16'h313F
`define GPF_DIR_RST_SMALL 16'h003B
`define GPF_DIR_RST_LARGE 16'h313F
`define GPF_ODS_RST 16'h0000
`define GPF_HOLD_RST 16'h0000
`define GPF_RESP_OKAY 2'h0
`define GPF_RESP_SLVERR 2'h2
`endif

// ### rtl/gpf_pkg.sv
/*
  Types shared by the port F block.
  Assumes the defines header sits beside it.
*/
`default_nettype none
`include "gpf_defines.svh"
package gpf_pkg;
  typedef logic [`GPF_NPINS-1:0] gpf_pins_t;
  // One register write: which register, which alias, which data.
  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] alias_op;
    logic [31:0] data;
  } gpf_wr_s;
  typedef enum logic [1:0] {
    GPF_IDLE = 2'b00,
    GPF_RESP = 2'b01
  } gpf_bus_e;
endpackage : gpf_pkg
`default_nettype wire

// ### rtl/gpf_pin_sync.sv
/*
  Three-stage pin input synchroniser with a change detector.
  Assumes CLK-domain reset already synchronised.
*/
`default_nettype none
`include "gpf_defines.svh"
module gpf_pin_sync
  import gpf_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronised reset, active low.
  input wire gpf_pins_t pin_in, // Raw pin levels.
  output gpf_pins_t level, // Settled level.
  output gpf_pins_t changed // Pulse when a level changes.
);
  gpf_pins_t s1_q, s2_q, s3_q, lvl_q;
  gpf_pins_t s1_d, s2_d, s3_d, lvl_d;

  // A change counts once the second and third stages agree.
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < `GPF_NPINS; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // Stage registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
  assign changed = lvl_q ^ lvl_d;
endmodule : gpf_pin_sync
`default_nettype wire

// ### rtl/gpf_port.sv
/*
  Port F parallel I/O with clear/set/invert aliases, pull-ups and change notify.
  Assumes an AXI4-Lite master on CLK and a pad ring resolving pin enables.
*/
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none
`include "gpf_defines.svh"
module gpf_port
  import gpf_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1 // Selects the larger package pin set.
) (
  input wire logic CLK, // System clock, 200 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic [15:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [15:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY, // Read data ready.
  input wire logic [15:0] PIN_IN, // Pin levels from pads.
  output logic [15:0] PIN_OUT, // Pin drive value.
  output logic [15:0] PIN_OE, // Pin drive enable.
  output logic [15:0] PIN_PULLUP_EN, // Weak pull-up enables.
  input wire logic CMP_REF_OUT_EN, // Comparator reference output on its pin.
  output logic CMP_REF_PIN_SEL, // Pad switches analog output onto pin.
  output logic IRQ // Change notification interrupt, level.
);
  localparam logic [15:0] IMPL = LARGE_PKG ? `GPF_MASK_LARGE : `GPF_MASK_SMALL;
  localparam logic [15:0] DIR_RST = LARGE_PKG ? `GPF_DIR_RST_LARGE : `GPF_DIR_RST_SMALL;
  localparam int CMP_PIN = 0;

  logic rs1_q, rst_n_q;
  // Reset release through two flip-flops.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rs1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n_q <= rs1_q;
    end
  end

  gpf_pins_t lvl, chg;
  gpf_pin_sync u_sync (
    .clk(CLK),
    .rst_n(rst_n_q),
    .pin_in(PIN_IN),
    .level(lvl),
    .changed(chg)
  );

  // Register file state.
  gpf_pins_t dir_q, dir_d, hold_q, hold_d, ods_q, ods_d;
  gpf_pins_t pu_q, pu_d, cn_q, cn_d, ist_q, ist_d, imk_q, imk_d;
  // Bus state.
  gpf_bus_e wst_q, wst_d, rst_q, rst_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [15:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  gpf_wr_s wr;
  logic wr_en, wr_ok, rd_take, rd_ok, rd_ist;
  logic [3:0] rd_sel, wstrb_q, wstrb_d;
  logic [15:0] rdv;

  // Maps an address to a register index; 15 means unmapped.
  function automatic logic [3:0] decode(input logic [15:0] a);
    logic [15:0] base;
    base = {a[15:4], 4'h0};
    case (base)
      `GPF_OFF_DIR: decode = 4'd0;
      `GPF_OFF_SAMPLE: decode = 4'd1;
      `GPF_OFF_HOLD: decode = 4'd2;
      `GPF_OFF_ODS: decode = 4'd3;
      `GPF_OFF_PULLUP: decode = 4'd4;
      `GPF_OFF_NOTIFY: decode = 4'd5;
      `GPF_OFF_ISTAT: decode = 4'd6;
      `GPF_OFF_IMASK: decode = 4'd7;
      default: decode = 4'hF;
    endcase
    if (a[1:0] != 2'h0) begin
      decode = 4'hF;
    end
  endfunction : decode

  // Applies a plain or alias write to one register.
  function automatic gpf_pins_t apply(input gpf_pins_t cur, input logic [1:0] op, input gpf_pins_t v);
    case (op)
      `GPF_ALIAS_CLR: apply = cur & ~v;
      `GPF_ALIAS_SET: apply = cur | v;
      `GPF_ALIAS_INV: apply = cur ^ v;
      default: apply = v;
    endcase
  endfunction : apply

  // Write channel: take address and data in either order, then respond.
  always_comb begin
    wst_d = wst_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awa_d = awa_q;
    wd_d = wd_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    wr_en = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_d = 1'b1;
      awa_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_d = 1'b1;
      wd_d = S_AXI_WDATA;
      wstrb_d = S_AXI_WSTRB;
    end
    case (wst_q)
      GPF_IDLE: begin
        if (aw_got_q && w_got_q) begin
          wr_en = 1'b1;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          bresp_d = wr_ok ? `GPF_RESP_OKAY : `GPF_RESP_SLVERR;
          wst_d = GPF_RESP;
        end
      end
      GPF_RESP: begin
        if (S_AXI_BREADY) begin
          wst_d = GPF_IDLE;
        end
      end
      default: wst_d = GPF_IDLE;
    endcase
  end

  // Decoded write; byte strobes gate all four lanes.
  always_comb begin
    wr.sel = decode(awa_q);
    wr.alias_op = awa_q[3:2];
    wr.data = wd_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wr_ok = (wr.sel != 4'hF);
  end

  // Register next values; hardware-set interrupt status wins over clear.
  always_comb begin
    gpf_pins_t v;
    v = wr.data[15:0] & IMPL;
    dir_d = dir_q;
    hold_d = hold_q;
    ods_d = ods_q;
    pu_d = pu_q;
    cn_d = cn_q;
    imk_d = imk_q;
    ist_d = ist_q;
    if (wr_en) begin
      case (wr.sel)
        4'd0: dir_d = apply(dir_q, wr.alias_op, v) & IMPL;
        4'd1: hold_d = apply(hold_q, wr.alias_op, v) & IMPL;
        4'd2: hold_d = apply(hold_q, wr.alias_op, v) & IMPL;
        4'd3: ods_d = apply(ods_q, wr.alias_op, v) & IMPL;
        4'd4: pu_d = apply(pu_q, wr.alias_op, v) & IMPL;
        4'd5: cn_d = apply(cn_q, wr.alias_op, v) & IMPL;
        4'd7: imk_d = apply(imk_q, wr.alias_op, v) & IMPL;
        default: ;
      endcase
    end
    if (rd_take && rd_ist) begin
      ist_d = '0;
    end
    ist_d = ist_d | (chg & cn_q & IMPL);
  end

  // Read channel: one read at a time, answered the cycle after address.
  always_comb begin
    rst_d = rst_q;
    rd_d = rd_q;
    rresp_d = rresp_q;
    rd_sel = decode(S_AXI_ARADDR);
    rd_ok = (rd_sel != 4'hF);
    rd_take = (rst_q == GPF_IDLE) && S_AXI_ARVALID;
    rd_ist = (rd_sel == 4'd6) && (S_AXI_ARADDR[3:2] == 2'h0);
    case (rd_sel)
      4'd0: rdv = dir_q;
      4'd1: rdv = lvl;
      4'd2: rdv = hold_q;
      4'd3: rdv = ods_q;
      4'd4: rdv = pu_q;
      4'd5: rdv = cn_q;
      4'd6: rdv = ist_q;
      4'd7: rdv = imk_q;
      default: rdv = '0;
    endcase
    case (rst_q)
      GPF_IDLE: begin
        if (rd_take) begin
          rd_d = {16'h0000, rdv & IMPL};
          rresp_d = rd_ok ? `GPF_RESP_OKAY : `GPF_RESP_SLVERR;
          rst_d = GPF_RESP;
        end
      end
      GPF_RESP: begin
        if (S_AXI_RREADY) begin
          rst_d = GPF_IDLE;
        end
      end
      default: rst_d = GPF_IDLE;
    endcase
  end

  // Pad drive per pin.
  gpf_pins_t out_d, oe_d;
  for (genvar i = 0; i < `GPF_NPINS; i++) begin : g_pin
    always_comb begin
      out_d[i] = ods_q[i] ? 1'b0 : hold_q[i];
      oe_d[i] = IMPL[i] && !dir_q[i] && !(ods_q[i] && hold_q[i]);
      if (i == CMP_PIN && CMP_REF_OUT_EN) begin
        oe_d[i] = 1'b0;
      end
    end
  end

  // All state registers but the reset synchroniser.
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dir_q <= DIR_RST;
      hold_q <= `GPF_HOLD_RST;
      ods_q <= `GPF_ODS_RST;
      pu_q <= '0;
      cn_q <= '0;
      ist_q <= '0;
      imk_q <= '0;
      wst_q <= GPF_IDLE;
      rst_q <= GPF_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      wstrb_q <= '0;
      rd_q <= '0;
      bresp_q <= '0;
      rresp_q <= '0;
      PIN_OUT <= '0;
      PIN_OE <= '0;
      PIN_PULLUP_EN <= '0;
      CMP_REF_PIN_SEL <= 1'b0;
      IRQ <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
    end else begin
      dir_q <= dir_d;
      hold_q <= hold_d;
      ods_q <= ods_d;
      pu_q <= pu_d;
      cn_q <= cn_d;
      ist_q <= ist_d;
      imk_q <= imk_d;
      wst_q <= wst_d;
      rst_q <= rst_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      wstrb_q <= wstrb_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      PIN_OUT <= out_d;
      PIN_OE <= oe_d;
      PIN_PULLUP_EN <= pu_d & IMPL;
      CMP_REF_PIN_SEL <= CMP_REF_OUT_EN;
      IRQ <= |(ist_d & imk_d);
      S_AXI_AWREADY <= !aw_got_d && (wst_d == GPF_IDLE);
      S_AXI_WREADY <= !w_got_d && (wst_d == GPF_IDLE);
      S_AXI_BVALID <= (wst_d == GPF_RESP);
      S_AXI_ARREADY <= (rst_d == GPF_IDLE);
      S_AXI_RVALID <= (rst_d == GPF_RESP);
    end
  end

  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rresp_q;
  // Assertions.
  AST_OUT_FOLLOWS_HOLD: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (!dir_q[1] && !ods_q[1] && IMPL[1]) |=> (PIN_OE[1] && PIN_OUT[1] == $past(hold_q[1])))
    else $error("Output pin does not follow hold register.");
  AST_OPEN_DRAIN_HIGH: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (ods_q[0] && hold_q[0]) |=> !PIN_OE[0]) else $error("Open-drain pin drives high.");
  AST_CMP_REF: assert property (@(posedge CLK) disable iff (!rst_n_q)
    CMP_REF_OUT_EN |=> (!PIN_OE[CMP_PIN] && CMP_REF_PIN_SEL)) else $error("Comparator pin still driven.");
  AST_CHANGE_STICKY: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (chg[4] && cn_q[4]) |=> ist_q[4]) else $error("Change event not recorded.");
  AST_PULLUP: assert property (@(posedge CLK) disable iff (!rst_n_q)
    PIN_PULLUP_EN[0] == $past(pu_d[0])) else $error("Pull-up enable mismatch.");
  AST_UPPER_ZERO: assert property (@(posedge CLK) disable iff (!rst_n_q)
    S_AXI_RVALID |-> (S_AXI_RDATA[31:16] == 16'h0000 && (S_AXI_RDATA[15:0] & ~IMPL) == 16'h0000))
    else $error("Unimplemented bits read nonzero.");
  AST_SET_ALIAS: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (wr_en && wr.sel == 4'd3 && wr.alias_op == `GPF_ALIAS_SET) |=> ((ods_q & $past(ods_q)) == $past(ods_q)))
    else $error("Set alias cleared a bit.");
  AST_INPUT_NO_DRIVE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    dir_q[2] |=> !PIN_OE[2]) else $error("Input pin driven.");
  AST_RD_ANSWER: assert property (@(posedge CLK) disable iff (!rst_n_q)
    (S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID) else $error("Read answer late.");
  COV_WRITE: cover property (@(posedge CLK) S_AXI_BVALID && S_AXI_BREADY);
  COV_READ: cover property (@(posedge CLK) S_AXI_RVALID && S_AXI_RREADY);
  COV_IRQ: cover property (@(posedge CLK) $rose(IRQ));
  COV_OD: cover property (@(posedge CLK) ods_q[0] && !dir_q[0]);
endmodule : gpf_port
`default_nettype wire

// ### sim/gpf_pin_model.sv
/*
  Pad and board model for port F: resolves each pin from the block, a pull-up and outside drivers.
  Assumes the bench drives ext_val and ext_en on the rising edge of clk.
*/
`default_nettype none
module gpf_pin_model
  import gpf_pkg::*;
(
  input wire logic clk, // System clock.
  input wire gpf_pins_t pin_out, // Block drive value.
  input wire gpf_pins_t pin_oe, // Block drive enable.
  input wire gpf_pins_t pull_en, // Weak pull-up enables.
  input wire gpf_pins_t ext_val, // Outside driver value.
  input wire gpf_pins_t ext_en, // Outside driver enable.
  output gpf_pins_t pin_lvl // Resolved pin level.
);
  timeunit 1ns;
  timeprecision 1ps;
  gpf_pins_t float_q = 16'hA5A5;
  // A pin that nobody holds wanders every cycle, so the synchroniser never settles on it and keeps the level it last settled.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // The block wins, then an outside driver, then the pull-up of a released pin.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? 1'b1 : float_q[i];
    end
  end
endmodule : gpf_pin_model
`default_nettype wire

// ### sim/testbench.sv
/*
  Self-checking bench for the port F block on its larger package.
  Assumes the pin model stands on the pads and that reads and writes answer within a few cycles.
*/
`default_nettype none
`include "gpf_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] M = {16'h0000, `GPF_MASK_LARGE};
  logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0, cmp_en = 0;
  logic [15:0] awaddr = 0, araddr = 0, ext_val = 0, ext_en = 0, b, pin_in, pout, poe, ppu;
  logic [31:0] wdata = 0, rdata, e, r, h, o;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, cmp_sel, irq;
  int err_count = 0, checks_done = 0;
  gpf_port #(.LARGE_PKG(1'b1)) u_dut (.CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(1'b1), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe), .PIN_PULLUP_EN(ppu),
    .CMP_REF_OUT_EN(cmp_en), .CMP_REF_PIN_SEL(cmp_sel), .IRQ(irq));
  gpf_pin_model u_pins (.clk(clk), .pin_out(pout), .pin_oe(poe), .pull_en(ppu), .ext_val(ext_val),
    .ext_en(ext_en), .pin_lvl(pin_in));
  // The 200 MHz system clock.
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // Compares one seen value with its expectation.
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // One write, address and data offered together and each released when taken.
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] xr);
    bit ad, wd, ta, tw;
    int n;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40 && !(ad && wd); n++) begin
      @(negedge clk);
      ta = awvalid && awready === 1'b1;
      tw = wvalid && wready === 1'b1;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    @(negedge clk);
    for (n = 0; n < 40 && bvalid !== 1'b1; n++) @(negedge clk);
    chk("bvalid", 1, {31'h0, bvalid});
    chk("bresp", {30'h0, xr}, {30'h0, bresp});
    @(posedge clk);
  endtask : wr
  // One read; compares data and response.
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [1:0] xr);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge clk);
    for (n = 0; n < 40 && arready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    arvalid <= 1'b0;
    @(negedge clk);
    for (n = 0; n < 40 && rvalid !== 1'b1; n++) @(negedge clk);
    chk("rvalid", 1, {31'h0, rvalid});
    chk("rresp", {30'h0, xr}, {30'h0, rresp});
    chk("rdata", x, rdata);
    @(posedge clk);
  endtask : rd
  // Expected base value after a plain, clear, set or invert write.
  function automatic logic [31:0] alias_f(input logic [31:0] v, input logic [31:0] w, input int k);
    logic [31:0] t;
    t = k == 0 ? w : k == 1 ? v & ~w : k == 2 ? v | w : v ^ w;
    return t & M;
  endfunction : alias_f
  // Cuts a hang short; the whole run needs about 1.5 us.
  initial begin
    #60us;
    err_count++;
    conclude();
  end
  // Main sequence.
  initial begin
    void'($urandom(59));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`GPF_OFF_DIR, {16'h0, `GPF_DIR_RST_LARGE}, `GPF_RESP_OKAY);
    chk("oe", 0, {16'h0, poe});
    rd(`GPF_OFF_ODS, 0, `GPF_RESP_OKAY);
    rd(16'h6200, 0, `GPF_RESP_SLVERR);
    wr(16'h6142, 0, `GPF_RESP_SLVERR);
    rd(`GPF_OFF_DIR, {16'h0, `GPF_DIR_RST_LARGE}, `GPF_RESP_OKAY);
    // Every alias of four registers, random words including the upper halfword.
    for (int i = 0; i < 4; i++) begin
      b = i == 0 ? `GPF_OFF_DIR : i == 1 ? `GPF_OFF_HOLD : i == 2 ? `GPF_OFF_ODS : `GPF_OFF_PULLUP;
      for (int k = 0; k < 4; k++) begin
        r = $urandom;
        wr(b + 16'(4 * k), r, `GPF_RESP_OKAY);
        e = alias_f(e, r, k);
        rd(b, e, `GPF_RESP_OKAY);
      end
    end
    repeat (2) @(posedge clk);
    chk("pullup", e, {16'h0, ppu});
    // Outputs, push-pull and open-drain, read back through the pins.
    repeat (4) begin
      h = $urandom;
      o = $urandom;
      wr(`GPF_OFF_DIR, 0, `GPF_RESP_OKAY);
      wr(`GPF_OFF_ODS, o, `GPF_RESP_OKAY);
      wr(`GPF_OFF_PULLUP, 32'hFFFF, `GPF_RESP_OKAY);
      wr(`GPF_OFF_SAMPLE, h, `GPF_RESP_OKAY);
      rd(`GPF_OFF_HOLD, h & M, `GPF_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("oe", M & ~(o & h), {16'h0, poe});
      chk("pin_out", h & ~o & M, {16'h0, pout});
      repeat (6) @(posedge clk);
      rd(`GPF_OFF_SAMPLE, h & M, `GPF_RESP_OKAY);
    end
    // Inputs driven from outside.
    wr(`GPF_OFF_DIR, 32'hFFFF, `GPF_RESP_OKAY);
    ext_en <= 16'hFFFF;
    ext_val <= 16'($urandom);
    repeat (8) @(posedge clk);
    rd(`GPF_OFF_SAMPLE, {16'h0, ext_val} & M, `GPF_RESP_OKAY);
    // Change notification on pin 4, masked and unmasked.
    wr(`GPF_OFF_NOTIFY, 32'h0010, `GPF_RESP_OKAY);
    wr(`GPF_OFF_IMASK, 32'h0010, `GPF_RESP_OKAY);
    // The drop on pin 4 records a change only if the random level was high.
    h = {16'h0000, ext_val} & 32'h0010;
    ext_val <= 16'h0000;
    repeat (8) @(posedge clk);
    wr(`GPF_OFF_ISTAT + 16'h4, 32'hFFFF, `GPF_RESP_OKAY);
    rd(`GPF_OFF_ISTAT, h, `GPF_RESP_OKAY);
    rd(`GPF_OFF_ISTAT, 0, `GPF_RESP_OKAY);
    ext_val <= 16'h0010;
    repeat (8) @(posedge clk);
    chk("irq", 1, {31'h0, irq});
    rd(`GPF_OFF_ISTAT, 32'h0010, `GPF_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 0, {31'h0, irq});
    ext_val <= 16'h0030;
    repeat (8) @(posedge clk);
    rd(`GPF_OFF_ISTAT, 0, `GPF_RESP_OKAY);
    wr(`GPF_OFF_IMASK, 0, `GPF_RESP_OKAY);
    ext_val <= 16'h0020;
    repeat (8) @(posedge clk);
    chk("irq", 0, {31'h0, irq});
    rd(`GPF_OFF_ISTAT, 32'h0010, `GPF_RESP_OKAY);
    // Comparator reference output takes pin 0 even when it is an output.
    ext_en <= 16'h0000;
    wr(`GPF_OFF_DIR, 0, `GPF_RESP_OKAY);
    wr(`GPF_OFF_ODS, 0, `GPF_RESP_OKAY);
    cmp_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk("cmp_sel", 1, {31'h0, cmp_sel});
    chk("oe0", 0, {31'h0, poe[0]});
    cmp_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe0", 1, {31'h0, poe[0]});
    // A set alias with only the low strobe may change only the low byte.
    wr(`GPF_OFF_PULLUP, 0, `GPF_RESP_OKAY);
    wstrb <= 4'h1;
    wr(`GPF_OFF_PULLUP + 16'h8, 32'hFFFF, `GPF_RESP_OKAY);
    wstrb <= 4'hF;
    rd(`GPF_OFF_PULLUP, M & 32'h00FF, `GPF_RESP_OKAY);
    conclude();
  end
endmodule : testbench
`default_nettype wire
